/* logic/sbdf_top.sv */
// baud rate generator and fifo configuration registers behind a wishbone slave
`timescale 1ns/1ps
module sbdf_top (
    input wire logic core_clk,
    input wire logic rst_n,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // channel mode from the rest of the serial channel
    input wire logic uart_mode,
    input wire logic [1:0] duplex_mode,
    input wire logic [2:0] rx_fill_level,
    // datapath conditions and interrupt requests
    input wire logic tx_path_empty,
    input wire logic rx_buffers_full,
    input wire logic tx_fifo_req,
    input wire logic rx_fifo_req,
    // generator and fifo configuration results
    output logic baud_tick,
    output logic fifo_enable,
    output logic [2:0] rx_fifo_depth,
    output logic [2:0] tx_fifo_depth,
    output logic [2:0] rx_depth_used,
    output logic tx_irq,
    output logic rx_irq,
    output logic tx_enable_clear,
    output logic rx_enable_clear,
    output logic irq
);
    // reset release through two flops
    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ---------------- register file ----------------
    sbdf_pkg::sbdf_brcr_s brcr; // baud_divider_control
    sbdf_pkg::sbdf_brcr_s next_brcr;
    logic [3:0] frac_k; // baud_fraction_control, fraction_k_value
    logic [3:0] next_frac_k;
    sbdf_pkg::sbdf_fcnf_s fcnf; // fifo_configuration
    sbdf_pkg::sbdf_fcnf_s next_fcnf;
    logic [sbdf_pkg::IRQ_W-1:0] irq_status; // sticky events
    logic [sbdf_pkg::IRQ_W-1:0] next_irq_status;
    logic [sbdf_pkg::IRQ_W-1:0] irq_mask; // one enables the event
    logic [sbdf_pkg::IRQ_W-1:0] next_irq_mask;
    logic ack; // registered acknowledge
    logic next_ack;
    logic [31:0] rdata; // registered read data
    logic [31:0] next_rdata;
    logic [sbdf_pkg::IRQ_W-1:0] irq_event; // this cycle's events

    logic req; // request waiting for its answer
    logic wr_now; // write commits on the acknowledge edge
    logic lane0; // all fields sit in byte lane 0

    assign req = wb_cyc_i & wb_stb_i & ~ack;
    assign wr_now = wb_cyc_i & wb_stb_i & ack & wb_we_i & lane0;
    assign lane0 = wb_sel_i[0];

    // next register values, read data and acknowledge
    always_comb begin
        next_brcr = brcr;
        next_frac_k = frac_k;
        next_fcnf = fcnf;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        next_ack = req; // one wait cycle, then ack for one cycle
        next_rdata = 32'h0000_0000; // upper bits and unmapped read zero
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                sbdf_pkg::ADDR_BAUD_DIV: next_rdata[7:0] = brcr;
                sbdf_pkg::ADDR_BAUD_FRAC: next_rdata[3:0] = frac_k;
                sbdf_pkg::ADDR_FIFO_CFG: next_rdata[7:0] = fcnf;
                sbdf_pkg::ADDR_IRQ_STATUS: next_rdata[3:0] = irq_status;
                sbdf_pkg::ADDR_IRQ_MASK: next_rdata[3:0] = irq_mask;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        if (wr_now) begin
            unique case (wb_adr_i)
                sbdf_pkg::ADDR_BAUD_DIV: next_brcr = wb_dat_i[7:0];
                // software owns K legality and its write order
                sbdf_pkg::ADDR_BAUD_FRAC: next_frac_k = wb_dat_i[3:0];
                sbdf_pkg::ADDR_FIFO_CFG: next_fcnf = wb_dat_i[7:0];
                sbdf_pkg::ADDR_IRQ_STATUS: begin
                    // write one clears
                    next_irq_status = irq_status & ~wb_dat_i[3:0];
                end
                sbdf_pkg::ADDR_IRQ_MASK: next_irq_mask = wb_dat_i[3:0];
                default: next_irq_mask = irq_mask; // unmapped write ignored
            endcase
        end
        // a fresh event wins over a clear in the same cycle
        next_irq_status = next_irq_status | irq_event;
    end

    // register the file
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            brcr <= sbdf_pkg::RST_BYTE;
            frac_k <= sbdf_pkg::RST_NIBBLE;
            fcnf <= sbdf_pkg::RST_BYTE;
            irq_status <= sbdf_pkg::RST_NIBBLE;
            irq_mask <= sbdf_pkg::RST_NIBBLE;
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            brcr <= next_brcr;
            frac_k <= next_frac_k;
            fcnf <= next_fcnf;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;
    assign irq = |(irq_status & irq_mask);

    // ---------------- baud rate generator ----------------
    logic [5:0] presc; // free running prescaler
    logic [5:0] next_presc;
    logic [4:0] div_cnt; // tap enables seen this period
    logic [4:0] next_div_cnt;
    logic [3:0] frac_phase; // position within 16 output periods
    logic [3:0] next_frac_phase;
    logic tick; // registered generator output
    logic next_tick;
    logic tap_en; // selected tap enable
    logic [4:0] div_n; // integer divisor 1..16
    logic frac_on; // fraction active
    logic add_one; // this period is N+1 long
    logic [4:0] last_cnt; // final count of this period

    // tap selection, divisor decode and period length
    always_comb begin
        unique case (brcr.generator_clock_select)
            sbdf_pkg::SBDF_TAP_DIV1: tap_en = 1'b1;
            sbdf_pkg::SBDF_TAP_DIV4: tap_en = presc[1:0] == sbdf_pkg::TAP_DIV4_MASK;
            sbdf_pkg::SBDF_TAP_DIV16: tap_en = presc[3:0] == sbdf_pkg::TAP_DIV16_MASK;
            sbdf_pkg::SBDF_TAP_DIV64: tap_en = presc == sbdf_pkg::TAP_DIV64_MASK;
        endcase
        // code zero stands for sixteen
        div_n = (brcr.integer_divisor == 4'h0) ? sbdf_pkg::DIV_CODE0_N
              : {1'b0, brcr.integer_divisor};
        // K is ignored outside uart mode or with the fraction off
        frac_on = brcr.frac_enable & uart_mode;
        // the long periods come first in each group of 16
        add_one = frac_on
                & ({1'b0, frac_phase} < (sbdf_pkg::FRAC_PERIODS - {1'b0, frac_k}));
        last_cnt = div_n + {4'h0, add_one} - 5'h01;
    end

    // next state of the generator
    always_comb begin
        next_presc = presc + 6'h01;
        next_div_cnt = div_cnt;
        next_frac_phase = frac_phase;
        next_tick = 1'b0;
        if (tap_en) begin
            // a shrinking divisor never strands the counter above its end
            if (div_cnt >= last_cnt) begin
                next_div_cnt = 5'h00;
                next_tick = 1'b1;
                next_frac_phase = frac_on ? frac_phase + 4'h1 : 4'h0;
            end else begin
                next_div_cnt = div_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            presc <= 6'h00;
            div_cnt <= 5'h00;
            frac_phase <= 4'h0;
            tick <= 1'b0;
        end else begin
            presc <= next_presc;
            div_cnt <= next_div_cnt;
            frac_phase <= next_frac_phase;
            tick <= next_tick;
        end
    end

    // divisor 1 is only meaningful for double-buffered clocked mode; software keeps to that
    assign baud_tick = tick;

    // ---------------- fifo configuration ----------------
    logic [2:0] next_rx_depth;
    logic [2:0] next_tx_depth;
    logic [2:0] next_rx_used;
    logic next_tx_irq;
    logic next_rx_irq;
    logic next_tx_clr;
    logic next_rx_clr;
    logic empty_d; // delayed condition for edge detect
    logic full_d;
    logic empty_rise;
    logic full_rise;

    // depth split, interrupt gating and automatic disable
    always_comb begin
        next_rx_depth = sbdf_pkg::DEPTH_NONE;
        next_tx_depth = sbdf_pkg::DEPTH_NONE;
        if (fcnf.fifo_enable) begin
            unique case (sbdf_pkg::sbdf_duplex_e'(duplex_mode))
                sbdf_pkg::SBDF_DPX_OFF: next_rx_depth = sbdf_pkg::DEPTH_NONE;
                sbdf_pkg::SBDF_DPX_HALF_RX: next_rx_depth = sbdf_pkg::DEPTH_HALF;
                sbdf_pkg::SBDF_DPX_HALF_TX: next_tx_depth = sbdf_pkg::DEPTH_HALF;
                sbdf_pkg::SBDF_DPX_FULL: begin
                    next_rx_depth = sbdf_pkg::DEPTH_FULL;
                    next_tx_depth = sbdf_pkg::DEPTH_FULL;
                end
            endcase
        end
        // limit to the fill level, never above the configured depth
        next_rx_used = next_rx_depth;
        if (fcnf.rx_bytes_used_select && rx_fill_level < next_rx_depth) begin
            next_rx_used = rx_fill_level;
        end
        // the enable bits only gate while the fifo is in use
        next_tx_irq = tx_fifo_req & (fcnf.tx_fifo_irq_enable | ~fcnf.fifo_enable);
        next_rx_irq = rx_fifo_req & (fcnf.rx_fifo_irq_enable | ~fcnf.fifo_enable);
        // act once per arrival of the condition, not every cycle it holds
        next_tx_clr = 1'b0;
        next_rx_clr = 1'b0;
        if (fcnf.auto_disable_control) begin
            unique case (sbdf_pkg::sbdf_duplex_e'(duplex_mode))
                sbdf_pkg::SBDF_DPX_OFF: next_tx_clr = 1'b0;
                sbdf_pkg::SBDF_DPX_HALF_RX: next_rx_clr = full_rise;
                sbdf_pkg::SBDF_DPX_HALF_TX: next_tx_clr = empty_rise;
                sbdf_pkg::SBDF_DPX_FULL: begin
                    next_tx_clr = empty_rise | full_rise;
                    next_rx_clr = empty_rise | full_rise;
                end
            endcase
        end
        irq_event = '0;
        irq_event[sbdf_pkg::IRQ_TX] = next_tx_irq;
        irq_event[sbdf_pkg::IRQ_RX] = next_rx_irq;
        irq_event[sbdf_pkg::IRQ_TX_OFF] = next_tx_clr;
        irq_event[sbdf_pkg::IRQ_RX_OFF] = next_rx_clr;
    end

    assign empty_rise = tx_path_empty & ~empty_d;
    assign full_rise = rx_buffers_full & ~full_d;

    // register the configuration results
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rx_fifo_depth <= sbdf_pkg::DEPTH_NONE;
            tx_fifo_depth <= sbdf_pkg::DEPTH_NONE;
            rx_depth_used <= sbdf_pkg::DEPTH_NONE;
            tx_irq <= 1'b0;
            rx_irq <= 1'b0;
            tx_enable_clear <= 1'b0;
            rx_enable_clear <= 1'b0;
            empty_d <= 1'b1; // path starts empty, no false edge
            full_d <= 1'b0;
        end else begin
            rx_fifo_depth <= next_rx_depth;
            tx_fifo_depth <= next_tx_depth;
            rx_depth_used <= next_rx_used;
            tx_irq <= next_tx_irq;
            rx_irq <= next_rx_irq;
            tx_enable_clear <= next_tx_clr;
            rx_enable_clear <= next_rx_clr;
            empty_d <= tx_path_empty;
            full_d <= rx_buffers_full;
        end
    end

    assign fifo_enable = fcnf.fifo_enable;
endmodule

/* logic/sbdf_pkg.sv */
// shared constants, register layouts and types of the baud divider and fifo config block
package sbdf_pkg;
    // wishbone byte offsets of the registers
    localparam logic [7:0] ADDR_BAUD_DIV = 8'h00;
    localparam logic [7:0] ADDR_BAUD_FRAC = 8'h04;
    localparam logic [7:0] ADDR_FIFO_CFG = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    // reset values, all zero
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    // divider figures
    localparam logic [4:0] DIV_CODE0_N = 5'h10; // integer code 0 means 16
    localparam logic [4:0] FRAC_PERIODS = 5'h10; // fraction cycle of 16 outputs
    localparam logic [1:0] TAP_DIV4_MASK = 2'h3;
    localparam logic [3:0] TAP_DIV16_MASK = 4'hF;
    localparam logic [5:0] TAP_DIV64_MASK = 6'h3F;
    // fifo depths in bytes
    localparam logic [2:0] DEPTH_NONE = 3'h0;
    localparam logic [2:0] DEPTH_HALF = 3'h4;
    localparam logic [2:0] DEPTH_FULL = 3'h2;
    // interrupt status bit positions
    localparam int IRQ_TX = 0;
    localparam int IRQ_RX = 1;
    localparam int IRQ_TX_OFF = 2;
    localparam int IRQ_RX_OFF = 3;
    localparam int IRQ_W = 4;

    // prescaler tap codes
    typedef enum logic [1:0] {
        SBDF_TAP_DIV1 = 2'b00,
        SBDF_TAP_DIV4 = 2'b01,
        SBDF_TAP_DIV16 = 2'b10,
        SBDF_TAP_DIV64 = 2'b11
    } sbdf_tap_e;

    // transfer direction set by the channel mode
    typedef enum logic [1:0] {
        SBDF_DPX_OFF = 2'b00,
        SBDF_DPX_HALF_RX = 2'b01,
        SBDF_DPX_HALF_TX = 2'b10,
        SBDF_DPX_FULL = 2'b11
    } sbdf_duplex_e;

    // baud_divider_control layout
    typedef struct packed {
        logic spare;
        logic frac_enable;
        sbdf_tap_e generator_clock_select;
        logic [3:0] integer_divisor;
    } sbdf_brcr_s;

    // fifo_configuration layout
    typedef struct packed {
        logic [2:0] spare;
        logic rx_bytes_used_select;
        logic tx_fifo_irq_enable;
        logic rx_fifo_irq_enable;
        logic auto_disable_control;
        logic fifo_enable;
    } sbdf_fcnf_s;
endpackage

/* verif/sbdf_asserts.sv */
// port checker for the baud divider and fifo config block
`timescale 1ns/1ps
module sbdf_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [1:0] duplex_mode,
    input wire logic tx_path_empty,
    input wire logic rx_buffers_full,
    input wire logic tx_fifo_req,
    input wire logic rx_fifo_req,
    input wire logic fifo_enable,
    input wire logic [2:0] rx_fifo_depth,
    input wire logic [2:0] tx_fifo_depth,
    input wire logic tx_irq,
    input wire logic rx_irq,
    input wire logic tx_enable_clear
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // a taken request is answered on the next edge
    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    // ack only for a request, and only one cycle long
    a_ack_one_pulse: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i) ##1 !wb_ack_o)
        else $error("ack without request or too long");
    a_upper_read_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_tx_irq_cause: assert property (tx_irq |-> $past(tx_fifo_req))
        else $error("tx irq without request");
    a_rx_irq_cause: assert property (rx_irq |-> $past(rx_fifo_req))
        else $error("rx irq without request");
    // with the fifo off the enable bit must not swallow the request
    a_tx_irq_pass: assert property ($past(tx_fifo_req && !fifo_enable) |-> tx_irq)
        else $error("tx irq lost with fifo off");
    a_depth_half_rx: assert property ($past(fifo_enable && duplex_mode == 2'b01) |->
        rx_fifo_depth == sbdf_pkg::DEPTH_HALF && tx_fifo_depth == sbdf_pkg::DEPTH_NONE)
        else $error("half rx depths wrong");
    a_depth_full_dpx: assert property ($past(fifo_enable && duplex_mode == 2'b11) |->
        rx_fifo_depth == sbdf_pkg::DEPTH_FULL && tx_fifo_depth == sbdf_pkg::DEPTH_FULL)
        else $error("full duplex depths wrong");
    // the clear is a single pulse that follows a datapath condition
    a_autodis_pulse: assert property (tx_enable_clear |->
        $past(tx_path_empty || rx_buffers_full) ##1 !tx_enable_clear)
        else $error("tx enable clear without cause");
    // main scenarios reached
    c_read_data: cover property (wb_ack_o && wb_dat_o != 32'h0);
    c_both_irq: cover property (tx_irq && rx_irq);
    c_autodis: cover property (tx_enable_clear);
endmodule
bind sbdf_top sbdf_chk chk_u (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .duplex_mode(duplex_mode),
    .tx_path_empty(tx_path_empty), .rx_buffers_full(rx_buffers_full), .fifo_enable(fifo_enable),
    .tx_fifo_req(tx_fifo_req), .rx_fifo_req(rx_fifo_req), .rx_fifo_depth(rx_fifo_depth),
    .tx_fifo_depth(tx_fifo_depth), .tx_irq(tx_irq), .rx_irq(rx_irq),
    .tx_enable_clear(tx_enable_clear));

/* verif/tb_top.sv */
// self-checking bench for the baud divider and fifo config block
`timescale 1ns/1ps
module tb_top;
    typedef struct {string name; logic [31:0] val;} sbdf_exp_s; // one awaited read
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, baud_tick, fifo_enable, tx_irq, rx_irq, tx_enable_clear, rx_enable_clear, irq;
    // path empty starts high so no auto-disable event fires early
    logic uart_mode = 1'b0, tx_path_empty = 1'b1, rx_buffers_full = 1'b0;
    logic tx_fifo_req = 1'b0, rx_fifo_req = 1'b0;
    logic [1:0] duplex_mode = 2'h0;
    logic [2:0] rx_fill_level = 3'h3, rx_fifo_depth, tx_fifo_depth, rx_depth_used;
    int err_total = 0, cmp_count = 0, cyc_n = 0, s, nl, ntx, nrx, de;
    logic [31:0] seed = 32'h0001_5812, r; // xorshift state
    sbdf_exp_s expq[$], ex;
    sbdf_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .uart_mode(uart_mode), .irq(irq),
        .duplex_mode(duplex_mode), .rx_fill_level(rx_fill_level), .tx_path_empty(tx_path_empty),
        .rx_buffers_full(rx_buffers_full), .tx_fifo_req(tx_fifo_req), .rx_fifo_req(rx_fifo_req),
        .baud_tick(baud_tick), .fifo_enable(fifo_enable), .rx_fifo_depth(rx_fifo_depth),
        .tx_fifo_depth(tx_fifo_depth), .rx_depth_used(rx_depth_used), .tx_irq(tx_irq),
        .rx_irq(rx_irq), .tx_enable_clear(tx_enable_clear), .rx_enable_clear(rx_enable_clear));
    // 125 MHz clock
    always #4 core_clk = ~core_clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    // every comparison goes through here
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        cmp_count++;
        if (v !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, v);
        end
    endtask
    // one classic cycle, held until ack is sampled; only the hang guard ends a wait
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] sl);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= sl;
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hF);
    endtask
    // the awaited value is queued before the request goes out
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        expq.push_back('{nm, e});
        wb(1'b0, a, 32'h0, 4'hF);
    endtask
    // skips two ticks to let a new setting settle, then sums k gaps
    task automatic span(input int k, input int lo, output int sum, output int nlong);
        int n;
        sum = 0;
        nlong = 0;
        repeat (2) begin
            do @(posedge core_clk); while (baud_tick !== 1'b1);
        end
        repeat (k) begin
            n = 0;
            do begin
                @(posedge core_clk);
                n++;
            end while (baud_tick !== 1'b1 && n < 3000);
            sum += n;
            nlong += (n > lo);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // read answers are taken off the queue in order
    always @(posedge core_clk) begin
        if (wb_ack_o === 1'b1 && wb_cyc_i === 1'b1 && wb_we_i === 1'b0) begin
            ex = expq.pop_front();
            chk(ex.name, ex.val, wb_dat_o);
        end
    end
    // hang guard, far above the thousand or so cycles the run needs
    always @(posedge core_clk) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            err_total++;
            results();
        end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        // reset values, unmapped place and a write without byte enable
        for (int i = 0; i < 6; i++)
            rd("reset value", 8'(i * 4), 32'h0);
        wr(8'h14, 32'hFF);
        rd("unmapped", 8'h14, 32'h0);
        wb(1'b1, sbdf_pkg::ADDR_FIFO_CFG, 32'hFF, 4'h0);
        rd("sel off", sbdf_pkg::ADDR_FIFO_CFG, 32'h0);
        r = xs(seed);
        wr(sbdf_pkg::ADDR_BAUD_FRAC, {24'hFFFFFF, r[7:4], r[3:0] | 4'h1});
        rd("fraction", sbdf_pkg::ADDR_BAUD_FRAC, {28'h0, r[3:0] | 4'h1});
        wr(sbdf_pkg::ADDR_FIFO_CFG, {24'hFFFFFF, 3'h0, r[12:8]});
        rd("fifo cfg", sbdf_pkg::ADDR_FIFO_CFG, {27'h0, r[12:8]});
        wr(sbdf_pkg::ADDR_IRQ_MASK, {28'h0, r[19:16]});
        rd("mask", sbdf_pkg::ADDR_IRQ_MASK, {28'h0, r[19:16]});
        $display("test registers done");
        // each tap with N=2: a gap is 2 tap periods
        for (int c = 0; c < 4; c++) begin
            wr(sbdf_pkg::ADDR_BAUD_DIV, {26'h0, 2'(c), 4'h2});
            span(2, 0, s, nl);
            chk("tap period", 32'(4 << (2 * c)), 32'(s));
        end
        wr(sbdf_pkg::ADDR_BAUD_DIV, 32'h0);
        span(2, 0, s, nl);
        chk("code 0", 32'h20, 32'(s));
        // K first, then fraction on: N=3, K=12 gives 4 long gaps in 16
        uart_mode <= 1'b1;
        wr(sbdf_pkg::ADDR_BAUD_FRAC, 32'hC);
        wr(sbdf_pkg::ADDR_BAUD_DIV, 32'h43);
        span(16, 3, s, nl);
        chk("fraction sum", 32'd52, 32'(s));
        chk("long gaps", 32'h4, 32'(nl));
        uart_mode <= 1'b0;
        span(4, 3, s, nl);
        chk("no uart", 32'hC, 32'(s));
        $display("test generator done");
        // depths per duplex, used bytes from fill level or full depth
        for (int d = 1; d < 4; d++) begin
            duplex_mode <= 2'(d);
            de = (d == 1) ? 4 : (d == 3) ? 2 : 0;
            wr(sbdf_pkg::ADDR_FIFO_CFG, 32'h11);
            repeat (2) @(posedge core_clk);
            chk("rx depth", 32'(de), 32'(rx_fifo_depth));
            chk("tx depth", (d == 2) ? 32'h4 : (d == 3) ? 32'h2 : 32'h0, 32'(tx_fifo_depth));
            chk("fifo enable", 32'h1, {31'h0, fifo_enable});
            chk("used fill", (de > 3) ? 32'h3 : 32'(de), 32'(rx_depth_used));
            wr(sbdf_pkg::ADDR_FIFO_CFG, 32'h01);
            repeat (2) @(posedge core_clk);
            chk("used max", 32'(de), 32'(rx_depth_used));
        end
        $display("test fifo depths done");
        // requests with the fifo irq enables off, then on, then with the fifo off
        for (int en = 0; en < 3; en++) begin
            wr(sbdf_pkg::ADDR_FIFO_CFG, (en == 2) ? 32'h00 : 32'h01 | 32'(en * 12));
            @(posedge core_clk);
            tx_fifo_req <= 1'b1;
            rx_fifo_req <= 1'b1;
            @(posedge core_clk);
            tx_fifo_req <= 1'b0;
            rx_fifo_req <= 1'b0;
            #1;
            chk("tx irq", 32'(en != 0), {31'h0, tx_irq});
            chk("rx irq", 32'(en != 0), {31'h0, rx_irq});
        end
        rd("status", sbdf_pkg::ADDR_IRQ_STATUS, 32'h3);
        wr(sbdf_pkg::ADDR_IRQ_MASK, 32'h1);
        #1;
        chk("irq line", 32'h1, {31'h0, irq});
        wr(sbdf_pkg::ADDR_IRQ_STATUS, 32'h1);
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd("status w1c", sbdf_pkg::ADDR_IRQ_STATUS, 32'h2);
        wr(sbdf_pkg::ADDR_IRQ_STATUS, 32'hF);
        $display("test interrupts done");
        // auto-disable: half tx on empty, then full duplex on rx full
        duplex_mode <= 2'h2;
        tx_path_empty <= 1'b0;
        wr(sbdf_pkg::ADDR_FIFO_CFG, 32'h03);
        for (int p = 0; p < 2; p++) begin
            ntx = 0;
            nrx = 0;
            @(posedge core_clk);
            if (p == 0)
                tx_path_empty <= 1'b1;
            else
                rx_buffers_full <= 1'b1;
            repeat (4) begin
                @(posedge core_clk);
                #1;
                ntx += tx_enable_clear;
                nrx += rx_enable_clear;
            end
            chk("tx clear", 32'h1, 32'(ntx));
            chk("rx clear", 32'(p), 32'(nrx));
            duplex_mode <= 2'h3;
        end
        rd("auto status", sbdf_pkg::ADDR_IRQ_STATUS, 32'hC);
        $display("test auto disable done");
        results();
    end
endmodule
